// ---- design/gate_window_pkg.sv ----
// Package for the trigger-gated measurement window.
// Assumes one 20 MHz clock; all delays and lengths are counted in its cycles.
package gate_window_pkg;

    // Widths
    localparam int CNT_W = 24;
    localparam int DATA_W = 16;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DELAY = 8'h04;
    localparam logic [7:0] OFS_LENGTH = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_ACCEPTED = 8'h10;
    localparam logic [7:0] OFS_TRIGGERS = 8'h14;

    // Control fields
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_STYLE_BIT = 1;
    localparam int CTRL_POLARITY_BIT = 2;

    // Status fields
    localparam int STAT_OPEN_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int STAT_TRIG_BIT = 2;

    // Reset values
    localparam logic RST_ENABLE = 1'b0;
    localparam logic RST_STYLE = 1'b0;
    localparam logic RST_POLARITY = 1'b1;
    localparam logic [CNT_W-1:0] RST_DELAY = 24'h000000;
    localparam logic [CNT_W-1:0] RST_LENGTH = 24'h000001;

    // Trigger style encodings
    localparam logic STYLE_EDGE = 1'b0;
    localparam logic STYLE_LEVEL = 1'b1;

    // AHB transfer type bit marking NONSEQ or SEQ
    localparam int HTRANS_ACTIVE_BIT = 1;

    typedef enum logic [1:0] {
        WIN_IDLE,
        WIN_DELAY,
        WIN_OPEN
    } win_state_t;

endpackage

// ---- design/trigger_style_select_if.sv ----
// Carrier between the register top, the trigger qualifier and the window timer.
// Assumes all three run on sys_clk.
interface trigger_style_select_if;
    import gate_window_pkg::*;

    logic enable;
    logic style;
    logic polarity;
    logic [CNT_W-1:0] delay;
    logic [CNT_W-1:0] length;
    logic qualify;
    logic busy;
    logic open;

    modport top (output enable, output style, output polarity, output delay,
        output length, input qualify, input busy, input open);
    modport qual (input enable, input style, input polarity, input busy,
        output qualify);
    modport timer (input enable, input delay, input length, input qualify,
        output busy, output open);
endinterface

// ---- design/trigger_qualifier.sv ----
// Qualifies the external gate trigger by style and polarity.
// Assumes the trigger input is already synchronous to sys_clk.
module trigger_qualifier
    import gate_window_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Trigger pin
    input wire logic gateTrigger,
    // Control carrier
    trigger_style_select_if.qual ctl
);

    logic prevTrigger;
    logic qualify;

    wire risingEdge = gateTrigger & ~prevTrigger;
    wire fallingEdge = ~gateTrigger & prevTrigger;
    wire edgeHit = ctl.polarity ? risingEdge : fallingEdge;
    wire levelHit = (gateTrigger == ctl.polarity);
    wire styleHit = (ctl.style == STYLE_LEVEL) ? levelHit : edgeHit;
    // Triggers landing during a delay or open period are dropped
    wire next_qualify = ctl.enable & ~ctl.busy & ~qualify & styleHit;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            prevTrigger <= 1'b0;
            qualify <= 1'b0;
        end else begin
            prevTrigger <= gateTrigger;
            qualify <= next_qualify;
        end
    end

    assign ctl.qualify = qualify;

endmodule // trigger_qualifier

// ---- design/window_timer.sv ----
// Delay then open-window sequencer driven by qualified triggers.
// Assumes delay and length are stable while a sequence runs.
module window_timer
    import gate_window_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Control carrier
    trigger_style_select_if.timer ctl
);

    win_state_t state;
    win_state_t next_state;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;

    wire lenZero = (ctl.length == '0);

    always_comb begin
        next_state = state;
        next_count = count;
        unique case (state)
            WIN_IDLE: begin
                if (ctl.qualify) begin
                    next_count = ctl.delay;
                    next_state = WIN_DELAY;
                end
            end
            WIN_DELAY: begin
                if (count != '0) begin
                    next_count = count - 1'b1;
                end else if (lenZero) begin
                    next_state = WIN_IDLE;
                end else begin
                    next_count = ctl.length - 1'b1;
                    next_state = WIN_OPEN;
                end
            end
            WIN_OPEN: begin
                if (count != '0) begin
                    next_count = count - 1'b1;
                end else begin
                    next_state = WIN_IDLE;
                end
            end
        endcase
        // Dropping the enable aborts any sequence at once
        if (!ctl.enable) begin
            next_state = WIN_IDLE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state <= WIN_IDLE;
            count <= '0;
        end else begin
            state <= next_state;
            count <= next_count;
        end
    end

    assign ctl.busy = (state != WIN_IDLE);
    assign ctl.open = (state == WIN_OPEN);

endmodule // window_timer

// ---- design/gate_window_top.sv ----
// Trigger-gated measurement window with an AHB-Lite register slave.
// Assumes one clock, synchronous trigger and detector inputs, one AHB master.
//
// What this block does
// - Qualify trigger by edge or level style
// - Wait programmed delay after qualifying trigger
// - Hold window open exactly programmed length
// - Status pin low closed, high open
// - Accept samples only while window open when enabled; pass every sample when disabled
// - Gate the detector output, not input
// - Status pin shows window only when enabled
// - Polarity picks rising or falling start edge, or high or low active level in level style
module gate_window_top
    import gate_window_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Gate trigger pin from the signal source
    input wire logic gateTrigger,
    // Gate status pin
    output logic gateOut,
    // Detector output path
    input wire logic [DATA_W-1:0] detData,
    input wire logic detValid,
    // Gated measurement path
    output logic [DATA_W-1:0] measData,
    output logic measValid
);

    trigger_style_select_if ctl ();

    // Register state
    logic enable;
    logic style;
    logic polarity;
    logic [CNT_W-1:0] delay;
    logic [CNT_W-1:0] length;
    logic [31:0] acceptedCount;
    logic [31:0] triggerCount;
    logic triggerSeen;

    // Bus phase state
    logic wrPend;
    logic [7:0] wrAddr;
    logic rdPend;
    logic [7:0] rdAddr;

    trigger_qualifier u_qual (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .gateTrigger(gateTrigger),
        .ctl(ctl.qual)
    );

    window_timer u_timer (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .ctl(ctl.timer)
    );

    assign ctl.enable = enable;
    assign ctl.style = style;
    assign ctl.polarity = polarity;
    assign ctl.delay = delay;
    assign ctl.length = length;

    // Address phase decode
    wire addrAccept = hsel & htrans[HTRANS_ACTIVE_BIT] & hready;
    wire writeAccept = addrAccept & hwrite;
    wire readAccept = addrAccept & ~hwrite;

    // Data phase write strobes
    wire wrCtrl = wrPend & (wrAddr == OFS_CTRL);
    wire wrDelay = wrPend & (wrAddr == OFS_DELAY);
    wire wrLength = wrPend & (wrAddr == OFS_LENGTH);
    wire wrStatus = wrPend & (wrAddr == OFS_STATUS);
    wire wrAccepted = wrPend & (wrAddr == OFS_ACCEPTED);
    wire wrTriggers = wrPend & (wrAddr == OFS_TRIGGERS);

    // Gating decisions
    wire windowOpen = ctl.open;
    wire passSample = enable ? windowOpen : 1'b1;
    wire acceptSample = detValid & enable & windowOpen;

    // Counters: a hit in the clearing cycle still counts
    wire [31:0] accBase = wrAccepted ? 32'h00000000 : acceptedCount;
    wire [31:0] next_acceptedCount = accBase + {31'h00000000, acceptSample};
    wire [31:0] trgBase = wrTriggers ? 32'h00000000 : triggerCount;
    wire [31:0] next_triggerCount = trgBase + {31'h00000000, ctl.qualify};
    wire next_triggerSeen = ctl.qualify | (triggerSeen & ~wrStatus);

    // Read data assembly
    wire [31:0] ctrlWord = {29'h00000000, polarity, style, enable};
    wire [31:0] statusWord = {29'h00000000, triggerSeen, ctl.busy, windowOpen};
    wire [31:0] delayWord = {8'h00, delay};
    wire [31:0] lengthWord = {8'h00, length};

    logic [31:0] readMux;

    always_comb begin
        unique case (rdAddr)
            OFS_CTRL: readMux = ctrlWord;
            OFS_DELAY: readMux = delayWord;
            OFS_LENGTH: readMux = lengthWord;
            OFS_STATUS: readMux = statusWord;
            OFS_ACCEPTED: readMux = acceptedCount;
            OFS_TRIGGERS: readMux = triggerCount;
            default: readMux = 32'h00000000;
        endcase
    end

    // Bus phase tracking
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            wrPend <= 1'b0;
            wrAddr <= 8'h00;
            rdPend <= 1'b0;
            rdAddr <= 8'h00;
        end else begin
            wrPend <= writeAccept;
            rdPend <= readAccept;
            if (addrAccept) begin
                wrAddr <= haddr[7:0];
                rdAddr <= haddr[7:0];
            end
        end
    end

    // One wait state on reads so a write just before is seen
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            hreadyout <= 1'b1;
            hrdata <= 32'h00000000;
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
            if (readAccept) begin
                hreadyout <= 1'b0;
            end else if (rdPend) begin
                hreadyout <= 1'b1;
                hrdata <= readMux;
            end
        end
    end

    // Control registers
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            enable <= RST_ENABLE;
            style <= RST_STYLE;
            polarity <= RST_POLARITY;
        end else if (wrCtrl) begin
            enable <= hwdata[CTRL_ENABLE_BIT];
            style <= hwdata[CTRL_STYLE_BIT];
            polarity <= hwdata[CTRL_POLARITY_BIT];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            delay <= RST_DELAY;
            length <= RST_LENGTH;
        end else begin
            if (wrDelay) begin
                delay <= hwdata[CNT_W-1:0];
            end
            if (wrLength) begin
                length <= hwdata[CNT_W-1:0];
            end
        end
    end

    // Status counters
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            acceptedCount <= 32'h00000000;
            triggerCount <= 32'h00000000;
            triggerSeen <= 1'b0;
        end else begin
            acceptedCount <= next_acceptedCount;
            triggerCount <= next_triggerCount;
            triggerSeen <= next_triggerSeen;
        end
    end

    // Gate status pin; held low while gating is off
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            gateOut <= 1'b0;
        end else begin
            gateOut <= enable & windowOpen;
        end
    end

    // Switch sits after the detector; closed window masks samples while enabled, all pass when disabled
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            measData <= '0;
            measValid <= 1'b0;
        end else begin
            measData <= detData;
            measValid <= detValid & passSample;
        end
    end

endmodule // gate_window_top

// ---- verification/trigger_source.sv ----
// Model of the external source of the gate trigger.
// Assumes the bench steers it on sys_clk.
module trigger_source (
    // Clock and control
    input wire logic sys_clk,
    input wire logic idleLvl,
    input wire logic fire,
    // Trigger pin
    output logic gateTrigger
);
    timeunit 1ns;
    timeprecision 1ns;
    // One clean logic pulse per request, repeated at the bench's pace
    always @(posedge sys_clk) begin
        gateTrigger <= fire ? !idleLvl : idleLvl;
    end
endmodule // trigger_source

// ---- verification/gate_window_top_asserts.sv ----
// Port-level checks of the gate window block.
// Assumes sys_clk and the synchronous active-low nrst of the top.
module gate_window_top_asserts
    import gate_window_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Bus
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // Gate and samples
    input wire logic gateOut,
    input wire logic [DATA_W-1:0] detData,
    input wire logic detValid,
    input wire logic [DATA_W-1:0] measData,
    input wire logic measValid
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    sequence s_rd; hsel && htrans[1] && hready && !hwrite; endsequence
    sequence s_wr; hsel && htrans[1] && hready && hwrite; endsequence
    sequence s_wait; !hreadyout ##1 hreadyout; endsequence
    property p_rd_wait; s_rd |=> s_wait; endproperty
    property p_wr_fast; s_wr |=> hreadyout; endproperty
    property p_okay; hresp == 1'b0; endproperty
    property p_hold; hreadyout && $past(hreadyout) |-> $stable(hrdata); endproperty
    property p_valid; measValid |-> $past(detValid); endproperty
    property p_data; measValid |-> measData == $past(detData); endproperty
    property p_open; detValid ##1 gateOut |-> measValid; endproperty
    property p_reset; $rose(nrst) |-> !gateOut && !measValid && hreadyout; endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
    a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
    a_okay: assert property (p_okay) else $error("response not okay");
    a_hold: assert property (p_hold) else $error("read data changed");
    a_valid: assert property (p_valid) else $error("sample without detector");
    a_data: assert property (p_data) else $error("sample data wrong");
    a_open: assert property (p_open) else $error("open sample lost");
    a_reset: assert property (p_reset) else $error("outputs not at reset");
endmodule // gate_window_top_asserts

bind gate_window_top gate_window_top_asserts u_chk (.sys_clk, .nrst, .hsel, .htrans,
    .hwrite, .hready, .hreadyout, .hresp, .hrdata, .gateOut, .detData, .detValid,
    .measData, .measValid);

// ---- verification/trigger_gated_measurement_window_tb_top.sv ----
// Self-checking bench for the gate window block.
// Assumes the design package, the bound checker and the trigger source model.
module trigger_gated_measurement_window_tb_top import gate_window_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 0, nrst = 0, hsel = 0, hwrite = 0, detValid = 0;
    logic idleLvl = 0, fire = 0, chkPass = 0, prevDv = 0, gated = 0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, lfsr = 32'h0001784e;
    logic [DATA_W-1:0] detData = 16'h0;
    wire logic hreadyout, hresp, gateOut, measValid, gateTrigger;
    wire logic [31:0] hrdata;
    wire logic [DATA_W-1:0] measData;
    int err_count = 0, compares = 0, cyc = 0, s = -1, first, hiN, expAcc, d, l;

    gate_window_top uut (.sys_clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .gateTrigger, .gateOut,
        .detData, .detValid, .measData, .measValid);
    trigger_source src (.sys_clk, .idleLvl, .fire, .gateTrigger);

    always #25 sys_clk = ~sys_clk;

    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // Cycle offset from the trigger at which the window is open
    function automatic logic inWin(input int t);
        return t >= 3 + d && t < 3 + d + l;
    endfunction

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task final_report;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        lfsr <= nxt(lfsr);
        detValid <= lfsr[3];
        detData <= lfsr[23:8];
    end

    // Sees the values that the design sampled at this same edge
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc > 5000) begin
            err_count++;
            final_report();
        end
        if (s < 0 && nrst && gateTrigger !== idleLvl)
            s = cyc;
        if (s >= 0 && gateOut === 1'b1) begin
            if (hiN == 0)
                first = cyc - s;
            hiN++;
        end
        if (s >= 0 && detValid && cyc - s >= 3 + d && cyc - s < 3 + d + l)
            expAcc++;
        if (chkPass)
            chk("ungated sample", prevDv, measValid);
        if (gated && s >= 0)
            chk("gated sample", prevDv && inWin(cyc - 1 - s), measValid);
        prevDv = detValid;
    end

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic pulse;
        @(posedge sys_clk) fire <= 1'b1;
        @(posedge sys_clk) fire <= 1'b0;
    endtask

    task automatic run_win(input logic st, input logic pol, input int dd, input int ll);
        bus(1'b1, OFS_CTRL, 32'h0);
        // Idle level moves only once gating is off, so no stray trigger
        idleLvl <= !pol;
        bus(1'b1, OFS_DELAY, dd);
        bus(1'b1, OFS_LENGTH, ll);
        bus(1'b1, OFS_TRIGGERS, 32'h0);
        bus(1'b1, OFS_ACCEPTED, 32'h0);
        bus(1'b1, OFS_CTRL, {29'h0, pol, st, 1'b1});
        d = dd;
        l = ll;
        hiN = 0;
        expAcc = 0;
        first = -1;
        s = -1;
        gated <= 1'b1;
        pulse();
        repeat (3) @(posedge sys_clk);
        // Lands inside the delay, so it must be ignored
        if (dd >= 6)
            pulse();
        repeat (dd + ll + 8) @(posedge sys_clk);
        gated <= 1'b0;
        chk("open delay", 4 + dd, first);
        chk("open length", ll, hiN);
        bus(1'b0, OFS_ACCEPTED, 32'h0);
        chk("accepted", expAcc, rd);
        bus(1'b0, OFS_TRIGGERS, 32'h0);
        chk("triggers", 32'h1, rd);
        $display("window test style %0d polarity %0d done", st, pol);
    endtask

    initial begin
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, 8'(i * 4), 32'h0);
            chk("reset value", i == 0 ? 32'h4 : i == 2 ? 32'h1 : 32'h0, rd);
        end
        // Keep the written word; the generator moves on every cycle
        d = lfsr;
        bus(1'b1, OFS_DELAY, d);
        bus(1'b0, OFS_DELAY, 32'h0);
        chk("delay readback", {8'h0, d[23:0]}, rd);
        $display("register test done");
        for (int k = 0; k < 4; k++)
            run_win(k[1], k[0], k == 1 ? 0 : 6 + lfsr[2:0], k == 1 ? 1 : 1 + lfsr[6:4]);
        bus(1'b1, OFS_CTRL, 32'h4);
        idleLvl <= 1'b0;
        s = -1;
        hiN = 0;
        pulse();
        // First compared sample is one taken after enable has dropped
        chkPass <= 1'b1;
        repeat (20) @(posedge sys_clk);
        chkPass <= 1'b0;
        chk("gate while disabled", 32'h0, hiN);
        $display("disabled test done");
        final_report();
    end
endmodule // trigger_gated_measurement_window_tb_top
